// File: rtl/duhp_host_port.sv
// duhp_host_port: parallel cpu port, interrupt pins and dma ready pins
// of a two-channel uart. the serial engine sits outside and exchanges
// bytes with the fifos through the duhp_line_type bundles.
// strobes, address and chip selects are taken as synchronous to sys_clk.

`timescale 1ns/100ps
`default_nettype none

module duhp_host_port
  import duhp_pkg::*;
#(
  parameter int DEPTH = DUHP_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire duhp_bus_type bus_in,
  input wire logic bus_read_strobe_n,
  input wire logic bus_write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  input wire duhp_line_type line_a,
  input wire duhp_line_type line_b,
  input wire logic [5:0] rx_trig_a,
  input wire logic [5:0] rx_trig_b,
  input wire logic chan_a_carrier_n,
  input wire logic chan_b_carrier_n,
  output logic [1:0] tx_byte_valid,
  output logic [15:0] tx_byte,
  output logic [1:0] serial_enable,
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe,
  output logic chan_b_irq_out,
  output logic chan_b_irq_oe,
  output logic chan_a_user_out2_n,
  output logic chan_b_user_out2_n,
  output logic chan_a_rx_avail_n,
  output logic chan_b_rx_avail_n,
  output logic chan_a_tx_space_n,
  output logic chan_b_tx_space_n,
  output logic [1:0] carrier_seen
);

  localparam int AW = $clog2(DEPTH);

  // pointers wrap on their own, so only powers of two are served
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("duhp_host_port: DEPTH must be a power of two");
  end

  // ==========================================================================
  // strobe edge detection shared by both channels
  logic rd_n_q, wr_n_q;
  duhp_bus_state_type bus_st_q;
  wire rd_fall = rd_n_q & ~bus_read_strobe_n;
  wire wr_fall = wr_n_q & ~bus_write_strobe_n;
  wire [1:0] sel = {~chan_b_select_n, ~chan_a_select_n};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      bus_st_q <= DUHP_BUS_IDLE;
    end else begin
      rd_n_q <= bus_read_strobe_n;
      wr_n_q <= bus_write_strobe_n;
      case (bus_st_q)
        DUHP_BUS_IDLE: begin
          if (rd_fall && |sel) begin
            bus_st_q <= DUHP_BUS_READ;
          end else if (wr_fall && |sel) begin
            bus_st_q <= DUHP_BUS_WRITE;
          end
        end
        DUHP_BUS_READ: begin
          if (bus_read_strobe_n) begin
            bus_st_q <= DUHP_BUS_IDLE;
          end
        end
        DUHP_BUS_WRITE: begin
          if (bus_write_strobe_n) begin
            bus_st_q <= DUHP_BUS_IDLE;
          end
        end
        default: bus_st_q <= DUHP_BUS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // per-channel registers, fifos and pin logic
  logic [7:0] rdata [2];
  logic [1:0] irq_pend, out2, rx_low, tx_low;
  duhp_line_type line [2];
  logic [5:0] trig [2];
  logic [1:0] cd_n;
  assign line[0] = line_a;
  assign line[1] = line_b;
  assign trig[0] = rx_trig_a;
  assign trig[1] = rx_trig_b;
  assign cd_n = {chan_b_carrier_n, chan_a_carrier_n};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [7:0] ier_q, mcr_q, fcr_q, spr_q, lsr_err_q, msr_q;
      logic [7:0] rxm [DEPTH];
      logic [7:0] txm [DEPTH];
      logic [AW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
      logic [AW:0] rx_cnt_q, tx_cnt_q;
      logic [7:0] rbyte_q;

      // bit 0 of each byte is the first bit on the serial line
      wire acc = sel[ch];
      wire wr_hit = wr_fall & acc;
      wire rd_hit = rd_fall & acc;
      wire rx_full = rx_cnt_q == (AW+1)'(DEPTH);
      wire tx_full = tx_cnt_q == (AW+1)'(DEPTH);
      wire rx_empty = rx_cnt_q == '0;
      wire tx_empty = tx_cnt_q == '0;
      wire rx_pop = rd_hit & (bus_in.addr == DUHP_ADDR_DATA) & ~rx_empty;
      wire tx_push = wr_hit & (bus_in.addr == DUHP_ADDR_DATA) & ~tx_full;
      wire rx_push = line[ch].rx_push & ~rx_full;
      wire tx_pop = line[ch].tx_pop & ~tx_empty;
      wire lsr_rd = rd_hit & (bus_in.addr == DUHP_ADDR_LSR);
      wire msr_rd = rd_hit & (bus_in.addr == DUHP_ADDR_MSR);
      wire dma1 = fcr_q[DUHP_FCR_DMA];

      // interrupt sources
      wire src_line = |lsr_err_q[DUHP_LSR_ERR_HI:DUHP_LSR_ERR_LO];
      wire src_rx = ~rx_empty;
      wire src_tx = tx_empty;
      wire src_modem = |msr_q[DUHP_MSR_FLAG_HI:0];
      wire [3:0] en = ier_q[3:0];
      wire p_line = src_line & en[DUHP_IER_LINE];
      wire p_rx = src_rx & en[DUHP_IER_RXDATA];
      wire p_tx = src_tx & en[DUHP_IER_TXEMPTY];
      wire p_modem = src_modem & en[DUHP_IER_MODEM];
      wire [3:0] isr_id = p_line ? DUHP_ID_LINE :
                          p_rx ? DUHP_ID_RX :
                          p_tx ? DUHP_ID_TX :
                          p_modem ? DUHP_ID_MODEM : DUHP_ID_NONE;
      wire [7:0] lsr = {2'h0, tx_empty, lsr_err_q[4:1], ~rx_empty};
      wire [7:0] msr = {~cd_n[ch], 3'h0, msr_q[3:0]};

      // register read mux
      assign rdata[ch] = (bus_in.addr == DUHP_ADDR_DATA) ? rxm[rx_rp_q] :
                         (bus_in.addr == DUHP_ADDR_IER) ? ier_q :
                         (bus_in.addr == DUHP_ADDR_ISR) ? {4'h0, isr_id} :
                         (bus_in.addr == DUHP_ADDR_MCR) ? mcr_q :
                         (bus_in.addr == DUHP_ADDR_LSR) ? lsr :
                         (bus_in.addr == DUHP_ADDR_MSR) ? msr :
                         (bus_in.addr == DUHP_ADDR_SPR) ? spr_q :
                         DUHP_RST_BYTE;

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          ier_q <= DUHP_RST_BYTE;
          mcr_q <= DUHP_RST_BYTE;
          fcr_q <= DUHP_RST_BYTE;
          spr_q <= DUHP_RST_BYTE;
          lsr_err_q <= DUHP_RST_BYTE;
          msr_q <= DUHP_RST_BYTE;
          rx_wp_q <= '0;
          rx_rp_q <= '0;
          tx_wp_q <= '0;
          tx_rp_q <= '0;
          rx_cnt_q <= '0;
          tx_cnt_q <= '0;
          rbyte_q <= DUHP_RST_BYTE;
        end else begin
          if (wr_hit) begin
            case (bus_in.addr)
              DUHP_ADDR_IER: ier_q <= bus_in.wdata;
              DUHP_ADDR_FCR: fcr_q <= bus_in.wdata;
              DUHP_ADDR_MCR: mcr_q <= bus_in.wdata;
              DUHP_ADDR_SPR: spr_q <= bus_in.wdata;
              default: ;
            endcase
          end
          if (tx_push) begin
            txm[tx_wp_q] <= bus_in.wdata;
            tx_wp_q <= tx_wp_q + 1'b1;
          end
          if (tx_pop) begin
            tx_rp_q <= tx_rp_q + 1'b1;
          end
          tx_cnt_q <= tx_cnt_q + {{AW{1'b0}}, tx_push} -
                      {{AW{1'b0}}, tx_pop};
          if (rx_push) begin
            rxm[rx_wp_q] <= line[ch].rx_byte;
            rx_wp_q <= rx_wp_q + 1'b1;
          end
          if (rx_pop) begin
            rx_rp_q <= rx_rp_q + 1'b1;
          end
          rx_cnt_q <= rx_cnt_q + {{AW{1'b0}}, rx_push} -
                      {{AW{1'b0}}, rx_pop};
          if (rd_hit) begin
            rbyte_q <= rdata[ch];
          end
          // set wins over the read clear
          lsr_err_q[4:1] <= (lsr_rd ? 4'h0 : lsr_err_q[4:1]) |
                            line[ch].rx_err;
          msr_q[3:0] <= (msr_rd ? 4'h0 : msr_q[3:0]) | line[ch].modem_flags;
        end
      end

      assign irq_pend[ch] = p_line | p_rx | p_tx | p_modem;
      assign out2[ch] = mcr_q[DUHP_MCR_OUT2];
      // mode 0 ignores the trigger mode 1 waits for it
      assign rx_low[ch] = dma1 ? (rx_cnt_q >= trig[ch] && !rx_empty)
                               : !rx_empty;
      // mode 0 drops once any byte is queued, mode 1 once full
      assign tx_low[ch] = dma1 ? !tx_full : tx_empty;
      assign tx_byte[8*ch +: 8] = txm[tx_rp_q];
      assign tx_byte_valid[ch] = ~tx_empty & ~sys_rst;
      assign carrier_seen[ch] = ~cd_n[ch];
    end
  endgenerate

  // ==========================================================================
  // bus data output: hold read data while the strobe stays low
  logic [7:0] dout_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dout_q <= DUHP_RST_BYTE;
    end else if (rd_fall) begin
      dout_q <= sel[0] ? rdata[0] : rdata[1];
    end
  end
  assign bus_data_out = dout_q;
  assign bus_data_oe = (bus_st_q == DUHP_BUS_READ) & ~bus_read_strobe_n;

  // ==========================================================================
  // pin outputs; one control bit sets both irq drive and user out2
  assign serial_enable = sys_rst ? 2'b00 : 2'b11;
  assign chan_a_irq_oe = out2[0];
  assign chan_b_irq_oe = out2[1];
  assign chan_a_irq_out = out2[0] & irq_pend[0];
  assign chan_b_irq_out = out2[1] & irq_pend[1];
  assign chan_a_user_out2_n = ~out2[0];
  assign chan_b_user_out2_n = ~out2[1];
  assign chan_a_rx_avail_n = ~rx_low[0];
  assign chan_b_rx_avail_n = ~rx_low[1];
  assign chan_a_tx_space_n = ~tx_low[0];
  assign chan_b_tx_space_n = ~tx_low[1];

endmodule

`default_nettype wire

// File: rtl/duhp_pkg.sv
// duhp_pkg: constants, types and register layout for the dual uart host port
// assumes one 200 MHz clock; both channels share the same register layout

package duhp_pkg;

  // ==========================================================================
  // register addresses on the three address inputs
  localparam logic [2:0] DUHP_ADDR_DATA = 3'h0;
  localparam logic [2:0] DUHP_ADDR_IER = 3'h1;
  localparam logic [2:0] DUHP_ADDR_ISR = 3'h2;
  localparam logic [2:0] DUHP_ADDR_FCR = 3'h2;
  localparam logic [2:0] DUHP_ADDR_MCR = 3'h4;
  localparam logic [2:0] DUHP_ADDR_LSR = 3'h5;
  localparam logic [2:0] DUHP_ADDR_MSR = 3'h6;
  localparam logic [2:0] DUHP_ADDR_SPR = 3'h7;

  // ==========================================================================
  // field positions
  localparam int DUHP_IER_RXDATA = 0;
  localparam int DUHP_IER_TXEMPTY = 1;
  localparam int DUHP_IER_LINE = 2;
  localparam int DUHP_IER_MODEM = 3;
  localparam int DUHP_MCR_OUT2 = 3;
  localparam int DUHP_FCR_DMA = 3;
  localparam int DUHP_LSR_RXDATA = 0;
  localparam int DUHP_LSR_ERR_LO = 1;
  localparam int DUHP_LSR_ERR_HI = 4;
  localparam int DUHP_LSR_TXEMPTY = 5;
  localparam int DUHP_MSR_FLAG_HI = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] DUHP_RST_BYTE = 8'h00;

  // ==========================================================================
  // buffer sizing
  localparam int DUHP_FIFO_DEPTH = 32;
  localparam int DUHP_FIFO_AW = 5;
  localparam logic [5:0] DUHP_TRIG_DEFAULT = 6'h01;

  // interrupt identification codes
  localparam logic [3:0] DUHP_ID_NONE = 4'h1;
  localparam logic [3:0] DUHP_ID_LINE = 4'h6;
  localparam logic [3:0] DUHP_ID_RX = 4'h4;
  localparam logic [3:0] DUHP_ID_TX = 4'h2;
  localparam logic [3:0] DUHP_ID_MODEM = 4'h0;

  // bus access from the cpu
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
  } duhp_bus_type;

  // per-channel status from the serial engine
  typedef struct packed {
    logic rx_push;
    logic [7:0] rx_byte;
    logic [3:0] rx_err;
    logic tx_pop;
    logic [3:0] modem_flags;
  } duhp_line_type;

  typedef enum logic [2:0] {
    DUHP_BUS_IDLE = 3'b001,
    DUHP_BUS_READ = 3'b010,
    DUHP_BUS_WRITE = 3'b100
  } duhp_bus_state_type;

endpackage

// File: sim/duhp_engine_model.sv
// engine model: serial engine and modem on the line side
// assumes the bench calls ev and cd at will; events last one cycle
`timescale 1ns/100ps
`default_nettype none
module duhp_engine_model
  import duhp_pkg::*;
(
  input wire logic sys_clk,
  output duhp_line_type line_a,
  output duhp_line_type line_b,
  output logic chan_a_carrier_n,
  output logic chan_b_carrier_n
);
  duhp_line_type ln [2] = '{'0, '0};
  logic [1:0] cd_n = 2'h3;
  assign line_a = ln[0];
  assign line_b = ln[1];
  assign chan_a_carrier_n = cd_n[0];
  assign chan_b_carrier_n = cd_n[1];
  // idle byte lines show the inverse so a stale byte never matches
  task automatic ev(input int ch, input duhp_line_type v);
    @(negedge sys_clk);
    ln[ch] = v;
    @(negedge sys_clk);
    ln[ch] = '0;
    ln[ch].rx_byte = ~v.rx_byte;
  endtask
  task automatic cd(input int ch, input logic found);
    @(negedge sys_clk);
    cd_n[ch] = !found;
    // one settled cycle before the caller looks at the result
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/duhp_host_port_properties.sv
// checker: port relations of duhp_host_port
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module duhp_host_port_properties
  import duhp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire duhp_bus_type bus_in,
  input wire logic bus_read_strobe_n,
  input wire logic bus_write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic bus_data_oe,
  input wire logic [1:0] tx_byte_valid,
  input wire logic [15:0] tx_byte,
  input wire logic [1:0] serial_enable,
  input wire logic chan_a_irq_out,
  input wire logic chan_a_irq_oe,
  input wire logic chan_b_irq_oe,
  input wire logic chan_a_user_out2_n,
  input wire logic chan_b_user_out2_n,
  input wire logic chan_a_tx_space_n,
  input wire logic chan_a_carrier_n,
  input wire logic chan_b_carrier_n,
  input wire logic [1:0] carrier_seen
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_OUT2_A: assert property (chan_a_irq_oe != chan_a_user_out2_n)
    else $error("out2 a pair");
  AST_OUT2_B: assert property (chan_b_irq_oe != chan_b_user_out2_n)
    else $error("out2 b pair");
  AST_IRQ_OE: assert property (chan_a_irq_out |-> chan_a_irq_oe)
    else $error("irq without drive");
  AST_RST_OUT: assert property ($fell(sys_rst) |-> !chan_a_irq_oe &&
    chan_a_user_out2_n && !chan_a_tx_space_n && !bus_data_oe)
    else $error("reset outputs");
  AST_SER_EN: assert property (!$past(sys_rst) |-> serial_enable == 2'h3)
    else $error("serial enable");
  AST_RD_OE: assert property (($fell(bus_read_strobe_n) &&
    !chan_a_select_n) ##2 !bus_read_strobe_n |-> bus_data_oe)
    else $error("read drive");
  AST_OE_REL: assert property (bus_read_strobe_n |-> !bus_data_oe)
    else $error("bus not released");
  AST_WR_TX: assert property (($fell(bus_write_strobe_n) &&
    !chan_a_select_n && chan_b_select_n && !tx_byte_valid[0] &&
    bus_in.addr == DUHP_ADDR_DATA) |=> tx_byte_valid[0] &&
    tx_byte[7:0] == $past(bus_in.wdata))
    else $error("write capture");
  AST_TX_EMPTY: assert property (!tx_byte_valid[0] |-> !chan_a_tx_space_n)
    else $error("tx ready");
  AST_CARRIER: assert property (carrier_seen ==
    ~{chan_b_carrier_n, chan_a_carrier_n})
    else $error("carrier");
  cover property ($fell(bus_write_strobe_n));
  cover property ($rose(chan_a_irq_out));
  cover property ($rose(chan_a_tx_space_n));
endmodule
`default_nettype wire

// File: sim/duhp_host_port_test.sv
// bench: directed scenarios for duhp_host_port
// assumes the engine model on the line side
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module duhp_host_port_test;
  import duhp_pkg::*;
  localparam int DEPTH = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  duhp_bus_type bus_in = '0;
  logic bus_read_strobe_n = 1'b1, bus_write_strobe_n = 1'b1;
  logic chan_a_select_n = 1'b1, chan_b_select_n = 1'b1;
  logic [5:0] trig = 6'h01;
  logic [7:0] q, bus_data_out;
  logic rd_oe, bus_data_oe;
  int error_cnt = 0;
  int n_compared = 0;
  duhp_line_type line_a, line_b, v;
  logic chan_a_carrier_n, chan_b_carrier_n;
  logic [1:0] tx_byte_valid, serial_enable, carrier_seen;
  logic [15:0] tx_byte;
  logic chan_a_irq_out, chan_a_irq_oe, chan_b_irq_out, chan_b_irq_oe;
  logic chan_a_user_out2_n, chan_b_user_out2_n;
  logic chan_a_rx_avail_n, chan_b_rx_avail_n;
  logic chan_a_tx_space_n, chan_b_tx_space_n;
  wire logic [4:0] pa = {chan_a_irq_oe, chan_a_user_out2_n,
    chan_a_rx_avail_n, chan_a_tx_space_n, bus_data_oe};
  always #2.5 sys_clk = ~sys_clk;
  duhp_engine_model m (.sys_clk, .line_a, .line_b, .chan_a_carrier_n,
    .chan_b_carrier_n);
  duhp_host_port #(.DEPTH(DEPTH)) dut (.sys_clk, .sys_rst, .bus_in,
    .bus_read_strobe_n, .bus_write_strobe_n, .chan_a_select_n,
    .chan_b_select_n, .bus_data_out, .bus_data_oe, .line_a, .line_b,
    .rx_trig_a(trig), .rx_trig_b(trig), .chan_a_carrier_n,
    .chan_b_carrier_n, .tx_byte_valid, .tx_byte, .serial_enable,
    .chan_a_irq_out, .chan_a_irq_oe, .chan_b_irq_out, .chan_b_irq_oe,
    .chan_a_user_out2_n, .chan_b_user_out2_n, .chan_a_rx_avail_n,
    .chan_b_rx_avail_n, .chan_a_tx_space_n, .chan_b_tx_space_n,
    .carrier_seen);
  // ==========================================================
  // bus access: held three cycles so the drive phase is seen
  task automatic acc(input logic ch, input logic wr, input logic [2:0] a,
      input logic [7:0] d);
    @(negedge sys_clk);
    bus_in = '{addr: a, wdata: d};
    chan_a_select_n = ch;
    chan_b_select_n = !ch;
    if (wr) bus_write_strobe_n = 1'b0;
    else bus_read_strobe_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    q = bus_data_out;
    rd_oe = bus_data_oe;
    {bus_read_strobe_n, bus_write_strobe_n} = 2'h3;
    {chan_a_select_n, chan_b_select_n} = 2'h3;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    `CHK("ser_en", 2'h0, serial_enable)
    `CHK("rst_a", 5'h0c, pa)
    `CHK("rst_b", 4'h6, {chan_b_irq_oe, chan_b_user_out2_n, chan_b_rx_avail_n, chan_b_tx_space_n})
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("run_en", 2'h3, serial_enable)
  endtask
  task automatic t_out2();
    acc(0, 1, DUHP_ADDR_MCR, 8'h08);
    `CHK("out2_a", 5'h14, pa)
    acc(0, 0, DUHP_ADDR_MCR, 8'h00);
    `CHK("mcr_rd", 9'h108, {rd_oe, q})
    acc(1, 1, DUHP_ADDR_MCR, 8'h08);
    `CHK("out2_b", 3'h4, {chan_b_irq_oe, chan_b_user_out2_n, chan_b_irq_out})
    acc(0, 1, DUHP_ADDR_MCR, 8'h00);
    `CHK("float_a", 5'h0c, pa)
    acc(0, 1, DUHP_ADDR_SPR, 8'h5a);
    acc(0, 0, DUHP_ADDR_SPR, 8'h00);
    `CHK("spr", 8'h5a, q)
  endtask
  task automatic t_irq();
    logic [2:0] clr [3] = '{DUHP_ADDR_DATA, DUHP_ADDR_LSR, DUHP_ADDR_MSR};
    logic [7:0] en [3] = '{8'h01, 8'h04, 8'h08};
    acc(0, 1, DUHP_ADDR_MCR, 8'h08); // out2 bit: irq drive on, user out2 pin low too
    acc(0, 1, DUHP_ADDR_IER, 8'h02);
    `CHK("irq_tx", 1'b1, chan_a_irq_out)
    acc(0, 0, DUHP_ADDR_ISR, 8'h00);
    `CHK("isr_tx", {4'h0, DUHP_ID_TX}, q)
    for (int i = 0; i < 3; i++) begin
      acc(0, 1, DUHP_ADDR_IER, en[i]);
      `CHK("irq_off", 1'b0, chan_a_irq_out)
      v = '0;
      v.rx_push = (i == 0);
      v.rx_byte = 8'h1d;
      v.rx_err = {3'h0, i == 1};
      v.modem_flags = {3'h0, i == 2};
      m.ev(0, v);
      `CHK("irq_on", 1'b1, chan_a_irq_out)
      `CHK("rx_rdy", i != 0, chan_a_rx_avail_n)
      acc(0, 0, clr[i], 8'h00);
      if (i == 0) `CHK("rx_dat", 8'h1d, q)
      `CHK("irq_clr", 1'b0, chan_a_irq_out)
      `CHK("rx_mt", 1'b1, chan_a_rx_avail_n)
    end
  endtask
  task automatic t_dma();
    trig = 6'h02;
    acc(0, 1, DUHP_ADDR_FCR, 8'h08);
    v = '0;
    v.rx_push = 1'b1;
    m.ev(0, v);
    `CHK("rx_trg", 1'b1, chan_a_rx_avail_n)
    m.ev(0, v);
    `CHK("rx_m1", 1'b0, chan_a_rx_avail_n)
    for (int i = 0; i < DEPTH; i++) begin
      `CHK("tx_free", 1'b0, chan_a_tx_space_n)
      acc(0, 1, DUHP_ADDR_DATA, 8'h10 + 8'(i));
    end
    `CHK("tx_full", 1'b1, chan_a_tx_space_n)
    `CHK("tx_head", 8'h10, tx_byte[7:0])
    v = '0;
    v.tx_pop = 1'b1;
    m.ev(0, v);
    `CHK("tx_pop", 1'b0, chan_a_tx_space_n)
    acc(0, 1, DUHP_ADDR_FCR, 8'h00);
    `CHK("tx_m0", 1'b1, chan_a_tx_space_n)
    repeat (DEPTH - 1) m.ev(0, v);
    `CHK("tx_m0e", 1'b0, chan_a_tx_space_n)
    m.cd(1, 1'b1);
    `CHK("carrier", 2'h2, carrier_seen)
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    t_reset();
    t_out2();
    t_reset();
    t_irq();
    t_dma();
    report_and_stop();
  end
  // a hang costs one mismatch; the run needs well under 20 us
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
bind duhp_host_port duhp_host_port_properties chk (.sys_clk, .sys_rst,
  .bus_in, .bus_read_strobe_n, .bus_write_strobe_n, .chan_a_select_n,
  .chan_b_select_n, .bus_data_oe, .tx_byte_valid, .tx_byte,
  .serial_enable, .chan_a_irq_out, .chan_a_irq_oe, .chan_b_irq_oe,
  .chan_a_user_out2_n, .chan_b_user_out2_n, .chan_a_tx_space_n,
  .chan_a_carrier_n, .chan_b_carrier_n, .carrier_seen);
`default_nettype wire
